// File: pcs_cfg.svh
// Constants for the PC Card slot target port
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH
`define PCS_ADDR_W 26
`define PCS_DATA_W 16
`define PCS_MODE_GENERIC16 3'h4
`define PCS_WAIT_CYCLES 4'h2
`endif

// File: pcs_pkg.sv
// Types for the PC Card slot target port
package pcs_pkg;
  typedef enum logic [1:0] {PCS_IDLE, PCS_WAIT, PCS_DONE} pcs_state_t;
  typedef enum logic [1:0] {PCS_SP_COMMON, PCS_SP_ATTR, PCS_SP_IO} pcs_space_t;
endpackage

// File: pcs_card_port.sv
// PC Card slot target port: space decode, lanes, strobes and wait
`timescale 1ns/1ns
`include "pcs_cfg.svh"
// Contract
// - Three spaces, IO, common and attribute, each 64 Mbyte.
// - Space select high means common memory, low attribute or IO.
// - Low enable alone: byte on low lane, address bit 0 picks byte.
// - High enable alone: odd byte on upper lane.
// - Both enables: full 16-bit word on all lines.
// - Target holds wait low as long as needed; host waits.
// - Device offers a 16-bit generic host bus mode.
// - Mode selection is captured at reset release.
// - After reset the bus signals follow the captured mode.
// - Wait held active until arbitration done and data ready.
// - Generic mode chosen when configuration inputs read 100.
module pcs_card_port
(
  input  wire logic                     sys_clk,
  input  wire logic                     srst,
  input  wire logic [2:0]               cfgPins,
  input  wire logic [`PCS_ADDR_W-1:0]   addr,
  input  wire logic                     space_select_n,
  input  wire logic                     low_lane_enable_n,
  input  wire logic                     high_lane_enable_n,
  input  wire logic                     mem_read_strobe_n,
  input  wire logic                     mem_write_strobe_n,
  input  wire logic                     io_read_strobe_n,
  input  wire logic                     io_write_strobe_n,
  input  wire logic [`PCS_DATA_W-1:0]   dataIn,
  output logic      [`PCS_DATA_W-1:0]   dataOut,
  output logic      [1:0]               dataOe,
  output logic                          cycle_extend_n,
  output logic                          modeActive,
  output logic                          userReq,
  output logic                          userWrite,
  output logic      [1:0]               userSpace,
  output logic      [`PCS_ADDR_W-1:0]   userAddr,
  output logic      [1:0]               userLanes,
  output logic      [`PCS_DATA_W-1:0]   userWdata,
  input  wire logic                     userBusy,
  input  wire logic [`PCS_DATA_W-1:0]   userRdata
);

  // Pin inputs cross three stages; a change counts when stages 2 and 3 agree
  localparam int NPIN = 7;
  logic [NPIN-1:0] s1_r, s2_r, s3_r, pin_r;
  logic [NPIN-1:0] s1_nxt, s2_nxt, s3_nxt, pin_nxt;
  logic [`PCS_ADDR_W-1:0] addrS1_r, addrS2_r;
  logic [`PCS_DATA_W-1:0] dinS1_r, dinS2_r;

  always_comb
  begin
    s1_nxt = {space_select_n, low_lane_enable_n, high_lane_enable_n,
              mem_read_strobe_n, mem_write_strobe_n,
              io_read_strobe_n, io_write_strobe_n};
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    pin_nxt = pin_r;
    for (int i = 0; i < NPIN; i++)
    begin
      if (s2_r[i] == s3_r[i])
        pin_nxt[i] = s3_r[i];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      s1_r  <= '1;
      s2_r  <= '1;
      s3_r  <= '1;
      pin_r <= '1;
    end
    else
    begin
      s1_r  <= s1_nxt;
      s2_r  <= s2_nxt;
      s3_r  <= s3_nxt;
      pin_r <= pin_nxt;
    end
  end

  // Address and data are held stable by the host while strobes are low
  always_ff @(posedge sys_clk)
  begin
    addrS1_r <= addr;
    addrS2_r <= addrS1_r;
    dinS1_r  <= dataIn;
    dinS2_r  <= dinS1_r;
  end

  logic spSel, loEn, hiEn, mRd, mWr, ioRd, ioWr;
  assign {spSel, loEn, hiEn, mRd, mWr, ioRd, ioWr} = ~pin_r;
  // spSel here is active high of the inverted pin: 1 means pin low

  // Mode capture at the first clock edge after reset release
  logic       capDone_r, capDone_nxt;
  logic       mode_r, mode_nxt;
  always_comb
  begin
    capDone_nxt = 1'b1;
    mode_nxt = mode_r;
    if (!capDone_r)
      mode_nxt = (cfgPins == `PCS_MODE_GENERIC16);
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      capDone_r <= 1'b0;
      mode_r    <= 1'b0;
    end
    else
    begin
      capDone_r <= capDone_nxt;
      mode_r    <= mode_nxt;
    end
  end
  assign modeActive = mode_r;

  // Space decode from the select level and the strobe family in use
  function automatic logic [1:0] decodeSpace(input logic selLow,
                                             input logic ioCycle);
    if (!selLow)
      decodeSpace = pcs_pkg::PCS_SP_COMMON;
    else if (ioCycle)
      decodeSpace = pcs_pkg::PCS_SP_IO;
    else
      decodeSpace = pcs_pkg::PCS_SP_ATTR;
  endfunction

  logic anyEn, ioCyc, rdCyc, wrCyc, start;
  assign anyEn = loEn | hiEn;
  assign ioCyc = ioRd | ioWr;
  // Strobe family must match the space: IO strobes only with select low
  assign rdCyc = mRd | (ioRd & spSel);
  assign wrCyc = mWr | (ioWr & spSel);

  pcs_pkg::pcs_state_t state_r, state_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic        wait_r, wait_nxt;
  logic        req_r, req_nxt, wr_r, wr_nxt;
  logic [1:0]  sp_r, sp_nxt, lanes_r, lanes_nxt, oe_r, oe_nxt;
  logic [`PCS_ADDR_W-1:0] ua_r, ua_nxt;
  logic [`PCS_DATA_W-1:0] wd_r, wd_nxt, rd_r, rd_nxt;

  assign start = mode_r & anyEn & (rdCyc | wrCyc);

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    wait_nxt  = wait_r;
    req_nxt   = 1'b0;
    wr_nxt    = wr_r;
    sp_nxt    = sp_r;
    lanes_nxt = lanes_r;
    ua_nxt    = ua_r;
    wd_nxt    = wd_r;
    rd_nxt    = rd_r;
    oe_nxt    = oe_r;
    case (state_r)
      pcs_pkg::PCS_IDLE:
      begin
        oe_nxt = 2'h0;
        if (start)
        begin
          state_nxt = pcs_pkg::PCS_WAIT;
          cnt_nxt   = `PCS_WAIT_CYCLES;
          wait_nxt  = 1'b1;
          req_nxt   = 1'b1;
          wr_nxt    = wrCyc;
          sp_nxt    = decodeSpace(spSel, ioCyc);
          lanes_nxt = {hiEn, loEn};
          ua_nxt    = addrS2_r;
          // Write data passes unshifted; an odd byte stays on the upper lane when only hi is on
          wd_nxt    = dinS2_r;
        end
      end
      pcs_pkg::PCS_WAIT:
      begin
        if (cnt_r != 4'h0)
          cnt_nxt = cnt_r - 4'h1;
        else if (!userBusy)
        begin
          state_nxt = pcs_pkg::PCS_DONE;
          wait_nxt  = 1'b0;
          rd_nxt    = userRdata;
          if (!wr_r)
            oe_nxt = lanes_r;
        end
      end
      pcs_pkg::PCS_DONE:
      begin
        // Drop the lanes as soon as the enables or strobes go away
        if (!anyEn || !(rdCyc | wrCyc))
        begin
          state_nxt = pcs_pkg::PCS_IDLE;
          oe_nxt    = 2'h0;
        end
      end
      default:
      begin
        state_nxt = pcs_pkg::PCS_IDLE;
        wait_nxt  = 1'b0;
        oe_nxt    = 2'h0;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_r <= pcs_pkg::PCS_IDLE;
      cnt_r   <= 4'h0;
      wait_r  <= 1'b0;
      req_r   <= 1'b0;
      wr_r    <= 1'b0;
      sp_r    <= 2'h0;
      lanes_r <= 2'h0;
      ua_r    <= '0;
      wd_r    <= '0;
      rd_r    <= '0;
      oe_r    <= 2'h0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      wait_r  <= wait_nxt;
      req_r   <= req_nxt;
      wr_r    <= wr_nxt;
      sp_r    <= sp_nxt;
      lanes_r <= lanes_nxt;
      ua_r    <= ua_nxt;
      wd_r    <= wd_nxt;
      rd_r    <= rd_nxt;
      oe_r    <= oe_nxt;
    end
  end

  assign cycle_extend_n = ~wait_r;
  assign userReq   = req_r;
  assign userWrite = wr_r;
  assign userSpace = sp_r;
  assign userAddr  = ua_r;
  assign userLanes = lanes_r;
  assign userWdata = wd_r;
  assign dataOut   = rd_r;
  assign dataOe    = oe_r;

  wait_until_ready_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state_r == pcs_pkg::PCS_WAIT) |-> !cycle_extend_n)
    else $error("wait released before the cycle completed");
  wait_on_start_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state_r == pcs_pkg::PCS_IDLE && start) |=> !cycle_extend_n)
    else $error("wait not asserted one cycle after a start");
  idle_no_drive_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state_r == pcs_pkg::PCS_IDLE && !anyEn) |=> dataOe == 2'h0)
    else $error("data driven without a card enable");
  lane_match_a: assert property (@(posedge sys_clk) disable iff (srst)
    dataOe != 2'h0 |-> dataOe == userLanes)
    else $error("driven lanes differ from enabled lanes");
  no_mode_idle_a: assert property (@(posedge sys_clk) disable iff (srst)
    !modeActive |=> !userReq)
    else $error("cycle taken outside the selected mode");
  mode_capture_a: assert property (@(posedge sys_clk)
    $fell(srst) ##1 1'b1 |->
      modeActive == ($past(cfgPins) == `PCS_MODE_GENERIC16))
    else $error("mode not captured from configuration inputs");
  space_common_a: assert property (@(posedge sys_clk) disable iff (srst)
    (userReq && !$past(spSel)) |-> userSpace == 2'h0)
    else $error("common space not decoded from select high");
  write_no_drive_a: assert property (@(posedge sys_clk) disable iff (srst)
    userWrite |-> dataOe == 2'h0)
    else $error("data lines driven during a write");

endmodule

// File: pcs_host_model.sv
// Host slot controller model that drives the card port pins
`timescale 1ns/1ns
`include "pcs_cfg.svh"
module pcs_host_model
(
  input  wire logic                   sys_clk,
  output logic [`PCS_ADDR_W-1:0]      addr,
  output logic                        space_select_n,
  output logic                        low_lane_enable_n,
  output logic                        high_lane_enable_n,
  output logic                        mem_read_strobe_n,
  output logic                        mem_write_strobe_n,
  output logic                        io_read_strobe_n,
  output logic                        io_write_strobe_n,
  output logic [`PCS_DATA_W-1:0]      dataIn,
  input  wire logic                   cycle_extend_n,
  input  wire logic [`PCS_DATA_W-1:0] dataOut,
  input  wire logic [1:0]             dataOe
);
  // Enables and strobes go high; address, data and select flip so a stale value never looks valid
  task automatic idle();
    {low_lane_enable_n, high_lane_enable_n} = 2'h3;
    {mem_read_strobe_n, mem_write_strobe_n} = 2'h3;
    {io_read_strobe_n, io_write_strobe_n} = 2'h3;
    addr = ~addr;
    dataIn = ~dataIn;
    space_select_n = ~space_select_n;
  endtask

  initial
  begin
    addr = '0;
    dataIn = '0;
    space_select_n = 1'b0;
    idle();
  end

  task automatic access(input logic [1:0] sp, input logic wr,
    input logic [1:0] lanes, input logic [25:0] a, input logic [15:0] wd,
    output logic [15:0] rd, output logic [1:0] oe, output int wl,
    output bit ok);
    ok = 1'b0;
    wl = 0;
    rd = '0;
    oe = '0;
    @(posedge sys_clk);
    #1;
    addr = a;
    dataIn = wd;
    space_select_n = (sp == 2'h0);
    @(posedge sys_clk);
    #1;
    low_lane_enable_n = ~lanes[0];
    high_lane_enable_n = ~lanes[1];
    if (sp == 2'h2)
      {io_write_strobe_n, io_read_strobe_n} = wr ? 2'h1 : 2'h2;
    else
      {mem_write_strobe_n, mem_read_strobe_n} = wr ? 2'h1 : 2'h2;
    // Cycle stays open while the port extends it
    for (int n = 0; n < 60 && !ok; n++)
    begin
      // Look after the edge so the registered outputs have settled
      @(posedge sys_clk);
      #1;
      if (cycle_extend_n === 1'b0)
        wl++;
      else if (wl > 0)
      begin
        ok = 1'b1;
        rd = dataOut;
        oe = dataOe;
      end
    end
    idle();
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic poke(input logic sel, input logic [1:0] en,
    input logic ioRd, output logic [1:0] oeSeen);
    oeSeen = '0;
    @(posedge sys_clk);
    #1;
    space_select_n = sel;
    {high_lane_enable_n, low_lane_enable_n} = ~en;
    {io_read_strobe_n, mem_read_strobe_n} = ioRd ? 2'h1 : 2'h2;
    repeat (12)
    begin
      @(posedge sys_clk);
      oeSeen = oeSeen | dataOe;
    end
    #1;
    idle();
    repeat (6) @(posedge sys_clk);
  endtask
endmodule

// File: test_pc_card_slot_target_port.sv
// Self-checking bench for the card port with a host model
`timescale 1ns/1ns
`include "pcs_cfg.svh"
module test_pc_card_slot_target_port;
  logic sys_clk, srst, low_lane_enable_n, high_lane_enable_n;
  logic space_select_n, mem_read_strobe_n, mem_write_strobe_n;
  logic io_read_strobe_n, io_write_strobe_n, cycle_extend_n;
  logic modeActive, userReq, userWrite, userBusy;
  logic [2:0] cfgPins;
  logic [1:0] dataOe, userSpace, userLanes;
  logic [25:0] addr, userAddr;
  logic [15:0] dataIn, dataOut, userWdata, userRdata;
  logic [46:0] info;
  int reqs, fails, checks;

  pcs_card_port u_dut (.sys_clk, .srst, .cfgPins, .addr, .space_select_n,
    .low_lane_enable_n, .high_lane_enable_n, .mem_read_strobe_n,
    .mem_write_strobe_n, .io_read_strobe_n, .io_write_strobe_n, .dataIn,
    .dataOut, .dataOe, .cycle_extend_n, .modeActive, .userReq, .userWrite,
    .userSpace, .userAddr, .userLanes, .userWdata, .userBusy, .userRdata);
  pcs_host_model u_host (.sys_clk, .addr, .space_select_n,
    .low_lane_enable_n, .high_lane_enable_n, .mem_read_strobe_n,
    .mem_write_strobe_n, .io_read_strobe_n, .io_write_strobe_n, .dataIn,
    .cycle_extend_n, .dataOut, .dataOe);

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
    if (userReq === 1'b1)
    begin
      reqs <= reqs + 1;
      info <= {userWrite, userSpace, userLanes, userAddr, userWdata};
    end

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic do_reset(input logic [2:0] cfg);
    #1;
    srst = 1'b1;
    cfgPins = cfg;
    repeat (12) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    repeat (6) @(posedge sys_clk);
    check(modeActive, cfg == 3'h4);
    check({cycle_extend_n, dataOe}, 3'h4);
  endtask

  task automatic t_access();
    logic [1:0] sp[6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
    logic wr[6] = '{0, 1, 0, 1, 0, 1};
    logic [1:0] ln[6] = '{2'h3, 2'h3, 2'h1, 2'h2, 2'h1, 2'h3};
    logic [25:0] a[6] = '{26'h3ffffff, 26'h0, 26'h1, 26'h2a5, 26'h1234, 26'h2};
    logic [15:0] rd, m;
    logic [1:0] oe;
    int wl, r0;
    bit ok;
    for (int i = 0; i < 6; i++)
    begin
      r0 = reqs;
      m = {{8{ln[i][1]}}, {8{ln[i][0]}}};
      // A fresh read word each time so stale read data cannot pass
      userRdata = 16'ha5c0 + 16'(i);
      u_host.access(sp[i], wr[i], ln[i], a[i], 16'h9d00 + 16'(i), rd, oe,
        wl, ok);
      if (!ok)
      begin
        fails++;
        wrap_up();
      end
      check(reqs - r0, 1);
      check(info[46:16], {wr[i], sp[i], ln[i], a[i]});
      if (wr[i])
        check(info[15:0], 16'h9d00 + 16'(i));
      else
      begin
        check(oe, ln[i]);
        check(rd & m, userRdata & m);
      end
    end
  endtask

  task automatic t_busy();
    logic [15:0] rd;
    logic [1:0] oe;
    int wl;
    bit ok;
    #1;
    userBusy = 1'b1;
    fork
      u_host.access(2'h2, 1'b0, 2'h3, 26'h40, 16'h0, rd, oe, wl, ok);
      begin
        repeat (20) @(posedge sys_clk);
        #1;
        userBusy = 1'b0;
      end
    join
    check({ok, wl >= 14}, 2'h3);
    check(rd, userRdata);
  endtask

  task automatic t_refuse();
    logic [1:0] oe;
    int r0;
    r0 = reqs;
    u_host.poke(1'b1, 2'h0, 1'b0, oe);
    check(oe, 2'h0);
    u_host.poke(1'b1, 2'h3, 1'b1, oe);
    check({reqs - r0, oe}, 0);
  endtask

  task automatic t_mode();
    logic [15:0] rd;
    logic [1:0] oe;
    int wl, r0;
    bit ok;
    do_reset(3'h0);
    r0 = reqs;
    u_host.access(2'h0, 1'b0, 2'h3, 26'h8, 16'h0, rd, oe, wl, ok);
    check({ok, reqs - r0}, 0);
    do_reset(3'h4);
  endtask

  initial
  begin
    {srst, userBusy, cfgPins, userRdata} = {1'b1, 1'b0, 3'h4, 16'hc35a};
    {reqs, fails, checks} = '0;
    do_reset(3'h4);
    t_access();
    t_busy();
    t_refuse();
    t_mode();
    t_access();
    wrap_up();
  end
endmodule
